// ===== core/mcs_pkg.sv
package mcs_pkg;
	localparam int NUM_REGS = 8;
	localparam int DATA_W = 8;

	// register indices into the decode vector
	localparam int IDX_STACK = 0;
	localparam int IDX_DPTR_LO = 1;
	localparam int IDX_DPTR_HI = 2;
	localparam int IDX_PWR = 3;
	localparam int IDX_CONF = 4;
	localparam int IDX_STATUS = 5;
	localparam int IDX_ACC = 6;
	localparam int IDX_AUX = 7;

	// direct-address offsets
	localparam logic [7:0] OFF_STACK = 8'h81;
	localparam logic [7:0] OFF_DPTR_LO = 8'h82;
	localparam logic [7:0] OFF_DPTR_HI = 8'h83;
	localparam logic [7:0] OFF_PWR = 8'h87;
	localparam logic [7:0] OFF_CONF = 8'haf;
	localparam logic [7:0] OFF_STATUS = 8'hd0;
	localparam logic [7:0] OFF_ACC = 8'he0;
	localparam logic [7:0] OFF_AUX = 8'hf0;
	localparam logic [7:0] REG_OFFS [NUM_REGS] = '{OFF_STACK, OFF_DPTR_LO, OFF_DPTR_HI,
		OFF_PWR, OFF_CONF, OFF_STATUS, OFF_ACC, OFF_AUX};

	// reset values
	localparam logic [7:0] RST_STACK = 8'h07;
	localparam logic [7:0] RST_DPTR_LO = 8'h00;
	localparam logic [7:0] RST_DPTR_HI = 8'h00;
	localparam logic [7:0] RST_PWR = 8'h00;
	localparam logic [7:0] RST_CONF = 8'h80;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [7:0] RST_AUX = 8'h00;

	// status word fields
	localparam int ST_CARRY = 7;
	localparam int ST_HALF = 6;
	localparam int ST_USER_A = 5;
	localparam int ST_BANK_HI = 4;
	localparam int ST_BANK_LO = 3;
	localparam int ST_WRAP = 2;
	localparam int ST_USER_B = 1;
	localparam int ST_PAR = 0;

	// power control and configuration fields
	localparam int PWR_BAUD_DBL = 7;
	localparam int CONF_KEEP = 7;
	localparam int CONF_UART_ENH = 6;
	localparam int CONF_SYNC_SEL = 5;
	localparam int CONF_IR_EN = 4;
	localparam int CONF_XRAM_HI = 1;
	localparam int CONF_XRAM_LO = 0;
	localparam logic [7:0] CONF_WR_MASK = 8'hf3;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ADD = 3'h1,
		OP_ADDC = 3'h2,
		OP_SUBB = 3'h3,
		OP_MUL = 3'h4,
		OP_DIV = 3'h5
	} mcs_alu_op_t;

	function automatic logic in_sfr_space(input logic [7:0] addr);
		return addr[7];
	endfunction
endpackage

// ===== core/mcs_dir_decode.sv
`timescale 1ns/1ps
module mcs_dir_decode (
	input logic [7:0] addr,
	input logic direct,
	output logic [mcs_pkg::NUM_REGS-1:0] sel
);
	// indirect cycles never select a register, even at a matching offset
	genvar i;
	generate
		for (i = 0; i < mcs_pkg::NUM_REGS; i++) begin : g_sel
			assign sel[i] = direct && mcs_pkg::in_sfr_space(addr) &&
				(addr == mcs_pkg::REG_OFFS[i]);
		end
	endgenerate
endmodule // mcs_dir_decode

// ===== core/mcs_acc_path.sv
`timescale 1ns/1ps
module mcs_acc_path (
	input logic [7:0] acc_cur,
	input logic core_we,
	input logic [7:0] core_data,
	input logic bus_we,
	input logic [7:0] bus_data,
	output logic [7:0] acc_next,
	output logic par_next
);
	// a direct store from the bus wins over a core result in the same cycle
	always_comb begin
		acc_next = acc_cur;
		if (core_we) begin
			acc_next = core_data;
		end
		if (bus_we) begin
			acc_next = bus_data;
		end
		par_next = ^acc_next;
	end
endmodule // mcs_acc_path

// ===== core/mcs_sfr_bank.sv
`timescale 1ns/1ps
module mcs_sfr_bank #(
	parameter logic [7:0] CONF_RESET = mcs_pkg::RST_CONF
) (
	input logic mclk,
	input logic rst_n,
	input logic [7:0] sfr_addr,
	input logic sfr_direct,
	input logic sfr_wr,
	input logic sfr_rd,
	input logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_ack,
	input logic core_acc_we,
	input logic [7:0] core_acc_data,
	input logic core_aux_we,
	input logic [7:0] core_aux_data,
	input logic core_dptr_we,
	input logic [15:0] core_dptr_data,
	input logic core_dptr_inc,
	input logic core_stack_push,
	input logic core_stack_pop,
	input logic core_flag_we,
	input mcs_pkg::mcs_alu_op_t core_alu_op,
	input logic core_carry,
	input logic core_half,
	input logic core_wrap,
	input logic [7:0] ir_carrier_pin_sel,
	output logic [7:0] acc_q,
	output logic [7:0] aux_q,
	output logic [7:0] status_word,
	output logic [1:0] bank_sel,
	output logic [15:0] data_ptr,
	output logic [7:0] stack_top_index,
	output logic baud_double,
	output logic uart_enhance_en,
	output logic sync_port_select,
	output logic ir_carrier_en,
	output logic [7:0] ir_mod_pin_mask,
	output logic xram_movx_en
);
	typedef struct packed {
		logic [7:0] stack;
		logic [7:0] dptr_lo;
		logic [7:0] dptr_hi;
		logic [7:0] pwr;
		logic [7:0] conf;
		logic [7:0] status;
		logic [7:0] acc;
		logic [7:0] aux;
		logic [7:0] rdata;
		logic ack;
		logic uart_enh;
		logic sync_sel;
		logic ir_en;
		logic [7:0] mod_mask;
		logic movx_en;
	} mcs_bank_state_t;

	localparam logic [7:0] CONF_RST_M = CONF_RESET & mcs_pkg::CONF_WR_MASK;
	localparam mcs_bank_state_t ST_RESET = '{
		stack: mcs_pkg::RST_STACK,
		dptr_lo: mcs_pkg::RST_DPTR_LO,
		dptr_hi: mcs_pkg::RST_DPTR_HI,
		pwr: mcs_pkg::RST_PWR,
		conf: CONF_RST_M,
		status: mcs_pkg::RST_STATUS,
		acc: mcs_pkg::RST_ACC,
		aux: mcs_pkg::RST_AUX,
		rdata: 8'h00,
		ack: 1'b0,
		uart_enh: CONF_RST_M[mcs_pkg::CONF_UART_ENH],
		sync_sel: CONF_RST_M[mcs_pkg::CONF_SYNC_SEL],
		ir_en: CONF_RST_M[mcs_pkg::CONF_IR_EN],
		mod_mask: 8'h00,
		movx_en: |CONF_RST_M[mcs_pkg::CONF_XRAM_HI:mcs_pkg::CONF_XRAM_LO]
	};

	mcs_bank_state_t st_ff;
	mcs_bank_state_t nxt_st;
	logic [mcs_pkg::NUM_REGS-1:0] sel;
	logic [7:0] acc_next;
	logic par_next;
	logic [15:0] dptr_cur;
	logic stat_wr;

	mcs_dir_decode u_decode (
		.addr(sfr_addr),
		.direct(sfr_direct),
		.sel(sel)
	);

	mcs_acc_path u_acc (
		.acc_cur(st_ff.acc),
		.core_we(core_acc_we),
		.core_data(core_acc_data),
		.bus_we(sfr_wr && sel[mcs_pkg::IDX_ACC]),
		.bus_data(sfr_wdata),
		.acc_next(acc_next),
		.par_next(par_next)
	);

	assign dptr_cur = {st_ff.dptr_hi, st_ff.dptr_lo};
	assign stat_wr = sfr_wr && sel[mcs_pkg::IDX_STATUS];

	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = 1'b0;
		nxt_st.rdata = 8'h00;

		// core-side updates; bus stores below override them
		if (core_stack_push) begin
			nxt_st.stack = st_ff.stack + 8'h01;
		end else if (core_stack_pop) begin
			nxt_st.stack = st_ff.stack - 8'h01;
		end
		if (core_dptr_we) begin
			nxt_st.dptr_lo = core_dptr_data[7:0];
			nxt_st.dptr_hi = core_dptr_data[15:8];
		end else if (core_dptr_inc) begin
			{nxt_st.dptr_hi, nxt_st.dptr_lo} = dptr_cur + 16'h0001;
		end
		if (core_aux_we) begin
			nxt_st.aux = core_aux_data;
		end
		if (core_flag_we) begin
			case (core_alu_op)
				mcs_pkg::OP_ADD, mcs_pkg::OP_ADDC: begin
					nxt_st.status[mcs_pkg::ST_CARRY] = core_carry;
					nxt_st.status[mcs_pkg::ST_HALF] = core_half;
					nxt_st.status[mcs_pkg::ST_WRAP] = core_wrap;
				end
				mcs_pkg::OP_SUBB, mcs_pkg::OP_MUL, mcs_pkg::OP_DIV: begin
					nxt_st.status[mcs_pkg::ST_CARRY] = core_carry;
					nxt_st.status[mcs_pkg::ST_WRAP] = core_wrap;
				end
				default: begin
				end
			endcase
		end

		// direct stores; indirect cycles never get a select
		if (sfr_wr) begin
			if (sel[mcs_pkg::IDX_STACK]) begin
				nxt_st.stack = sfr_wdata;
			end
			if (sel[mcs_pkg::IDX_DPTR_LO]) begin
				nxt_st.dptr_lo = sfr_wdata;
			end
			if (sel[mcs_pkg::IDX_DPTR_HI]) begin
				nxt_st.dptr_hi = sfr_wdata;
			end
			if (sel[mcs_pkg::IDX_PWR]) begin
				// reserved power bits are kept as written; software owns them
				nxt_st.pwr = sfr_wdata;
			end
			if (sel[mcs_pkg::IDX_CONF]) begin
				nxt_st.conf = sfr_wdata & mcs_pkg::CONF_WR_MASK;
			end
			if (sel[mcs_pkg::IDX_STATUS]) begin
				// user flags and bank select are plain storage
				nxt_st.status[7:1] = sfr_wdata[7:1];
			end
			if (sel[mcs_pkg::IDX_AUX]) begin
				nxt_st.aux = sfr_wdata;
			end
		end

		// parity tracks the accumulator value that lands with this edge
		nxt_st.acc = acc_next;
		nxt_st.status[mcs_pkg::ST_PAR] = par_next;

		// decoded configuration outputs registered alongside the register
		nxt_st.uart_enh = nxt_st.conf[mcs_pkg::CONF_UART_ENH];
		nxt_st.sync_sel = nxt_st.conf[mcs_pkg::CONF_SYNC_SEL];
		nxt_st.ir_en = nxt_st.conf[mcs_pkg::CONF_IR_EN];
		nxt_st.mod_mask = nxt_st.conf[mcs_pkg::CONF_IR_EN] ? ir_carrier_pin_sel : 8'h00;
		nxt_st.movx_en = |nxt_st.conf[mcs_pkg::CONF_XRAM_HI:mcs_pkg::CONF_XRAM_LO];

		// read answers show the value held before this edge
		if ((sfr_rd || sfr_wr) && (|sel)) begin
			nxt_st.ack = 1'b1;
		end
		if (sfr_rd) begin
			if (sel[mcs_pkg::IDX_STACK]) begin
				nxt_st.rdata = st_ff.stack;
			end
			if (sel[mcs_pkg::IDX_DPTR_LO]) begin
				nxt_st.rdata = st_ff.dptr_lo;
			end
			if (sel[mcs_pkg::IDX_DPTR_HI]) begin
				nxt_st.rdata = st_ff.dptr_hi;
			end
			if (sel[mcs_pkg::IDX_PWR]) begin
				nxt_st.rdata = st_ff.pwr;
			end
			if (sel[mcs_pkg::IDX_CONF]) begin
				nxt_st.rdata = st_ff.conf;
			end
			if (sel[mcs_pkg::IDX_STATUS]) begin
				nxt_st.rdata = st_ff.status;
			end
			if (sel[mcs_pkg::IDX_ACC]) begin
				nxt_st.rdata = st_ff.acc;
			end
			if (sel[mcs_pkg::IDX_AUX]) begin
				nxt_st.rdata = st_ff.aux;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sfr_rdata = st_ff.rdata;
	assign sfr_ack = st_ff.ack;
	assign acc_q = st_ff.acc;
	assign aux_q = st_ff.aux;
	assign status_word = st_ff.status;
	assign bank_sel = st_ff.status[mcs_pkg::ST_BANK_HI:mcs_pkg::ST_BANK_LO];
	assign data_ptr = dptr_cur;
	assign stack_top_index = st_ff.stack;
	assign baud_double = st_ff.pwr[mcs_pkg::PWR_BAUD_DBL];
	assign uart_enhance_en = st_ff.uart_enh;
	assign sync_port_select = st_ff.sync_sel;
	assign ir_carrier_en = st_ff.ir_en;
	assign ir_mod_pin_mask = st_ff.mod_mask;
	assign xram_movx_en = st_ff.movx_en;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	logic arith_all;
	logic arith_nohalf;
	assign arith_all = core_flag_we && (core_alu_op inside {mcs_pkg::OP_ADD, mcs_pkg::OP_ADDC,
		mcs_pkg::OP_SUBB, mcs_pkg::OP_MUL, mcs_pkg::OP_DIV});
	assign arith_nohalf = core_flag_we && (core_alu_op inside {mcs_pkg::OP_SUBB,
		mcs_pkg::OP_MUL, mcs_pkg::OP_DIV, mcs_pkg::OP_NONE});

	a_mapped_ack: assert property (
		(sfr_rd || sfr_wr) && sfr_direct && (sfr_addr == mcs_pkg::OFF_CONF) |=> sfr_ack
	) else $error("mapped direct access not acknowledged");

	a_indirect_blocked: assert property (
		sfr_wr && !sfr_direct && !core_acc_we && !core_aux_we |=> (acc_q == $past(acc_q))
			&& (aux_q == $past(aux_q)) && !sfr_ack
	) else $error("indirect access reached a register");

	a_carry_update: assert property (
		arith_all && !stat_wr |=> status_word[mcs_pkg::ST_CARRY] == $past(core_carry)
	) else $error("carry not taken from arithmetic result");

	a_half_only_add: assert property (
		arith_nohalf && !stat_wr |=> $stable(status_word[mcs_pkg::ST_HALF])
	) else $error("half carry changed by non-add operation");

	a_wrap_update: assert property (
		arith_all && !stat_wr |=> status_word[mcs_pkg::ST_WRAP] == $past(core_wrap)
	) else $error("signed wrap not taken from arithmetic result");

	a_user_flags: assert property (
		stat_wr |=> (status_word[mcs_pkg::ST_USER_A] == $past(sfr_wdata[5]))
			&& (status_word[mcs_pkg::ST_USER_B] == $past(sfr_wdata[1]))
	) else $error("user flag not stored");

	a_bank_select: assert property (
		stat_wr ##1 !stat_wr |-> bank_sel == $past(sfr_wdata[4:3])
	) else $error("bank select does not follow status write");

	a_parity_even: assert property (
		(^{acc_q, status_word[mcs_pkg::ST_PAR]}) == 1'b0
	) else $error("parity bit not even over accumulator");

	a_parity_readonly: assert property (
		stat_wr && !core_acc_we |=> status_word[mcs_pkg::ST_PAR] == ^$past(acc_q)
	) else $error("parity bit took a written value");

	a_reset_values: assert property (
		@(posedge mclk) disable iff (1'b0)
		!rst_n |=> (stack_top_index == mcs_pkg::RST_STACK) && (data_ptr == 16'h0000)
			&& !baud_double
	) else $error("reset values wrong");

	a_conf_fields: assert property (
		sfr_wr && sel[mcs_pkg::IDX_CONF] |=> (uart_enhance_en == $past(sfr_wdata[6]))
			&& (sync_port_select == $past(sfr_wdata[5]))
	) else $error("uart or sync port select wrong");

	a_ir_gate: assert property (
		ir_carrier_en == 1'b0 |-> ir_mod_pin_mask == 8'h00
	) else $error("modulation applied while disabled");

	a_movx_gate: assert property (
		sfr_wr && sel[mcs_pkg::IDX_CONF] |=> xram_movx_en == (|$past(sfr_wdata[1:0]))
	) else $error("xram access gate wrong");

	a_conf_reserved: assert property (
		sfr_rd && sel[mcs_pkg::IDX_CONF] |=> sfr_rdata[3:2] == 2'b00
	) else $error("reserved configuration bits not zero");

	// refused cycles must leave the answer lines quiet, not just skip the store
	a_refused_silent: assert property (
		(sfr_rd || sfr_wr) && !sfr_direct |=> !sfr_ack && (sfr_rdata == 8'h00)
	) else $error("indirect access answered");

	a_upper_only: assert property (
		(sfr_rd || sfr_wr) && !sfr_addr[7] |=> !sfr_ack && (sfr_rdata == 8'h00)
	) else $error("lower data space reached the register bank");

	a_stack_store: assert property (
		sfr_wr && sel[mcs_pkg::IDX_STACK] |=> stack_top_index == $past(sfr_wdata)
	) else $error("stack pointer store lost");

	c_conf_write: cover property (sfr_wr && sel[mcs_pkg::IDX_CONF] ##1 ir_carrier_en);
	c_bank_three: cover property (stat_wr ##1 bank_sel == 2'b11);
	c_add_flags: cover property (core_flag_we && core_alu_op == mcs_pkg::OP_ADD && core_half);
	c_indirect_try: cover property (sfr_wr && !sfr_direct && sfr_addr == mcs_pkg::OFF_ACC);
	c_status_read: cover property (sfr_rd && sel[mcs_pkg::IDX_STATUS] ##1 sfr_ack);
endmodule // mcs_sfr_bank

// ===== tb/mcs_core_model.sv
`timescale 1ns/1ps
module mcs_core_model (
	input wire logic mclk,
	output logic [7:0] sfr_addr,
	output logic sfr_direct,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_wdata
);
	initial begin
		sfr_addr = 8'h00;
		sfr_direct = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end

	// one access per call, held across exactly one rising edge
	task automatic access(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d, input logic dir, input int gap);
		@(negedge mclk);
		sfr_wr = w;
		sfr_rd = r;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_direct = dir;
		@(negedge mclk);
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		// released lines show inverted junk so stale values cannot pass
		sfr_addr = ~a;
		sfr_wdata = ~d;
		sfr_direct = ~dir;
		repeat (gap) @(negedge mclk);
	endtask
endmodule // mcs_core_model

// ===== tb/mcs_sfr_bank_tb.sv
`timescale 1ns/1ps
module mcs_sfr_bank_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc_q, aux_q, status_word;
	logic sfr_direct, sfr_wr, sfr_rd, sfr_ack;
	logic core_acc_we = 0, core_aux_we = 0, core_dptr_we = 0, core_dptr_inc = 0;
	logic core_stack_push = 0, core_stack_pop = 0, core_flag_we = 0;
	logic core_carry = 0, core_half = 0, core_wrap = 0;
	logic [7:0] core_acc_data = 0, core_aux_data = 0, ir_carrier_pin_sel = 0;
	logic [15:0] core_dptr_data = 0, data_ptr;
	mcs_pkg::mcs_alu_op_t core_alu_op = mcs_pkg::OP_NONE;
	logic [1:0] bank_sel;
	logic [7:0] stack_top_index, ir_mod_pin_mask;
	logic baud_double, uart_enhance_en, sync_port_select, ir_carrier_en, xram_movx_en;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h0000003c;
	logic [31:0] r;
	logic [7:0] v, e, acc_sh, aux_sh;
	logic app_c, app_h;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;

	always #50 mclk = ~mclk;

	mcs_core_model i_core (.mclk, .sfr_addr, .sfr_direct, .sfr_wr, .sfr_rd, .sfr_wdata);

	mcs_sfr_bank i_dut (.mclk, .rst_n, .sfr_addr, .sfr_direct, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata, .sfr_ack, .core_acc_we, .core_acc_data, .core_aux_we,
		.core_aux_data, .core_dptr_we, .core_dptr_data, .core_dptr_inc, .core_stack_push,
		.core_stack_pop, .core_flag_we, .core_alu_op, .core_carry, .core_half,
		.core_wrap, .ir_carrier_pin_sel, .acc_q, .aux_q, .status_word, .bank_sel,
		.data_ptr, .stack_top_index, .baud_double, .uart_enhance_en, .sync_port_select,
		.ir_carrier_en, .ir_mod_pin_mask, .xram_movx_en);

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		exp_q.push_back(8'h00);
		i_core.access(1'b1, 1'b0, a, d, 1'b1, 0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		i_core.access(1'b0, 1'b1, a, 8'h00, 1'b1, 0);
	endtask

	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// every answer must match the oldest outstanding note
	always @(negedge mclk) begin
		if (sfr_ack === 1'b1) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("Error at %0t: got %h expected %h", $time, sfr_ack, 1'b0);
			end else
				check({8'h00, sfr_rdata}, {8'h00, exp_q.pop_front()});
		end else if (rst_n && sfr_ack !== 1'b0) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, sfr_ack, 1'b0);
		end
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		for (int k = 0; k < 8; k++) begin
			e = (k == mcs_pkg::IDX_STACK) ? 8'h07 : (k == mcs_pkg::IDX_CONF) ? 8'h80 : 8'h00;
			rd(mcs_pkg::REG_OFFS[k], e);
		end
		$display("reset values done");
		r = xs();
		@(negedge mclk);
		core_dptr_we = 1'b1;
		core_dptr_data = 16'h12ff;
		core_aux_we = 1'b1;
		core_aux_data = r[7:0];
		@(negedge mclk);
		core_dptr_we = 1'b0;
		core_aux_we = 1'b0;
		core_dptr_inc = 1'b1;
		core_stack_push = 1'b1;
		@(negedge mclk);
		core_dptr_inc = 1'b0;
		core_stack_push = 1'b0;
		core_stack_pop = 1'b1;
		check(data_ptr, 16'h1300);
		check({8'h00, stack_top_index}, 16'h0008);
		check({8'h00, aux_q}, {8'h00, r[7:0]});
		@(negedge mclk);
		core_stack_pop = 1'b0;
		rd(mcs_pkg::OFF_STACK, 8'h07);
		rd(mcs_pkg::OFF_DPTR_HI, 8'h13);
		rd(mcs_pkg::OFF_DPTR_LO, 8'h00);
		rd(mcs_pkg::OFF_AUX, r[7:0]);
		$display("core pointers done");
		acc_sh = 8'h00;
		for (int k = 0; k < 8; k++) begin
			r = xs();
			v = r[7:0];
			if (k == mcs_pkg::IDX_PWR) v = v & 8'h80;
			if (k == mcs_pkg::IDX_CONF) v = v | 8'h80;
			if (k == mcs_pkg::IDX_ACC) acc_sh = v;
			if (k == mcs_pkg::IDX_AUX) aux_sh = v;
			e = (k == mcs_pkg::IDX_CONF) ? (v & 8'hf3) : v;
			if (k == mcs_pkg::IDX_STATUS) e = {v[7:1], ^acc_sh};
			wr(mcs_pkg::REG_OFFS[k], v);
			rd(mcs_pkg::REG_OFFS[k], e);
		end
		$display("write readback done");
		i_core.access(1'b1, 1'b0, mcs_pkg::OFF_AUX, ~aux_sh, 1'b0, 0);
		i_core.access(1'b1, 1'b0, mcs_pkg::OFF_ACC, ~acc_sh, 1'b0, 0);
		i_core.access(1'b0, 1'b1, mcs_pkg::OFF_AUX, 8'h00, 1'b0, 0);
		i_core.access(1'b1, 1'b0, 8'h84, 8'h5a, 1'b1, 0);
		i_core.access(1'b0, 1'b1, 8'h7f, 8'h00, 1'b1, 0);
		rd(mcs_pkg::OFF_AUX, aux_sh);
		check({acc_q, aux_q}, {acc_sh, aux_sh});
		$display("refused access done");
		for (int b = 0; b < 4; b++) begin
			wr(mcs_pkg::OFF_STATUS, {3'b000, b[1:0], 3'b000});
			check({14'h0000, bank_sel}, {14'h0000, b[1:0]});
		end
		for (int o = 0; o <= 5; o++) begin
			r = xs();
			app_c = (o != 0);
			app_h = (o == 1 || o == 2);
			wr(mcs_pkg::OFF_STATUS, {~r[0], ~r[1], 3'b000, ~r[2], 2'b00});
			@(negedge mclk);
			core_flag_we = 1'b1;
			core_alu_op = mcs_pkg::mcs_alu_op_t'(o[2:0]);
			core_carry = r[0];
			core_half = r[1];
			core_wrap = r[2];
			@(negedge mclk);
			core_flag_we = 1'b0;
			check({8'h00, status_word & 8'hc4}, {8'h00, app_c ? r[0] : ~r[0],
				app_h ? r[1] : ~r[1], 3'b000, app_c ? r[2] : ~r[2], 2'b00});
		end
		$display("status flags done");
		repeat (4) begin
			r = xs();
			@(negedge mclk);
			core_acc_we = 1'b1;
			core_acc_data = r[7:0];
			@(negedge mclk);
			core_acc_we = 1'b0;
			core_acc_data = ~r[7:0];
			check({acc_q, 7'h00, status_word[0]}, {r[7:0], 7'h00, ^r[7:0]});
		end
		$display("parity done");
		for (int x = 0; x < 8; x++) begin
			r = xs();
			ir_carrier_pin_sel = r[15:8];
			v = {1'b1, r[1:0], x[2], 2'b00, x[1:0]};
			wr(mcs_pkg::OFF_CONF, v);
			check({4'h0, uart_enhance_en, sync_port_select, ir_carrier_en, xram_movx_en,
				ir_mod_pin_mask}, {4'h0, v[6], v[5], v[4], |v[1:0],
				v[4] ? r[15:8] : 8'h00});
		end
		for (int b = 1; b >= 0; b--) begin
			wr(mcs_pkg::OFF_PWR, {b[0], 7'h00});
			check({15'h0000, baud_double}, {15'h0000, b[0]});
		end
		$display("configuration done");
		@(negedge mclk);
		check(16'(exp_q.size()), 16'h0000);
		conclude();
	end
endmodule // mcs_sfr_bank_tb
